// file: rtl/vlrs_defines.vh
// What this block does
// - each per-entry bitmap is two 32-bit words, entries 0-31 then 32-63.
// - bitmap bits of unimplemented entries always read zero.
// - eoi bit is 1 exactly when state is 00, link flag 0, eoi flag 1.
// - empty bit is 1 when state is 00 and link flag 1 or eoi flag 0.
// - a 32-bit active priorities word marks each active preemption level.
// - acknowledge sets the priorities bit picked by the top five bits.
// - each end of interrupt clears only the lowest set priorities bit.
// - at most 64 entries; the count is shown in the type register.
// - entries above the implemented count read zero and ignore writes.
// - unused entry field bits read zero and ignore writes.
// - the state field is 00 invalid, 01 pending, 10 active, 11 both.
// - deactivating a linked entry sends a physical deactivate request.
// - the eoi maintenance flag is set while any eoi status bit is 1.
// - the six-bit count field holds implemented entries minus one.
`ifndef VLRS_DEFINES_VH
`define VLRS_DEFINES_VH

// register word addresses (8-bit address port)
`define VLRS_ADDR_TYPE      8'h00
`define VLRS_ADDR_MAINT     8'h01
`define VLRS_ADDR_EOI_LO    8'h02
`define VLRS_ADDR_EOI_HI    8'h03
`define VLRS_ADDR_EMPTY_LO  8'h04
`define VLRS_ADDR_EMPTY_HI  8'h05
`define VLRS_ADDR_APR       8'h06
`define VLRS_ADDR_ENTRY0    8'h40

// entry field positions
`define VLRS_F_LINK         31
`define VLRS_F_GRP1         30
`define VLRS_F_ST_HI        29
`define VLRS_F_ST_LO        28
`define VLRS_F_PRI_HI       27
`define VLRS_F_PRI_LO       23
`define VLRS_F_EOI          19
`define VLRS_F_PID_HI       19
`define VLRS_F_PID_LO       10
`define VLRS_F_VID_HI       9
`define VLRS_F_VID_LO       0
// implemented field bits; 22:20 unused
`define VLRS_ENTRY_MASK     32'hFF8FFFFF

// states
`define VLRS_ST_INVALID     2'h0
`define VLRS_ST_PENDING     2'h1
`define VLRS_ST_ACTIVE      2'h2
`define VLRS_ST_BOTH        2'h3

`define VLRS_MAX_ENTRIES    64
`define VLRS_APR_RESET      32'h00000000

`endif

// file: rtl/vlrs_status.v
`timescale 1ns/100ps
`default_nettype none
`include "vlrs_defines.vh"

module vlrs_status
#(
  parameter NUM_ENTRIES = 64
)
(
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  // virtual cpu interface events (same clock)
  input  wire        ack_valid,
  input  wire [5:0]  ack_entry,
  input  wire        eoi_valid,
  input  wire        deact_valid,
  input  wire [5:0]  deact_entry,
  // physical deactivate request
  output reg         phys_deact_q,
  output reg  [9:0]  linked_physical_id_q,
  // maintenance flag
  output reg         maint_eoi_q
);

  ////////////////////////////////////////////////////////////////////////////
  localparam [31:0] CNT_FULL = NUM_ENTRIES - 1;
  localparam [5:0]  CNT_M1   = CNT_FULL[5:0];

  reg  [31:0] entry_q [0:`VLRS_MAX_ENTRIES-1];
  reg  [31:0] apr_q;
  reg  [31:0] apr_d;
  reg  [63:0] eoi_map;
  reg  [63:0] empty_map;
  reg  [31:0] rd_d;
  reg  [31:0] low_bit;
  wire [5:0]  wr_idx = reg_addr[5:0];
  wire        wr_entry = reg_wr && (reg_addr[7:6] == 2'h1);
  wire [31:0] ack_e = entry_q[ack_entry];
  wire [31:0] de_e  = entry_q[deact_entry];
  integer     i;
  integer     j;

  ////////////////////////////////////////////////////////////////////////////
  // live status bitmaps
  always @*
  begin
    eoi_map   = 64'h0;
    empty_map = 64'h0;
    for (i = 0; i < `VLRS_MAX_ENTRIES; i = i + 1)
    begin
      if (i < NUM_ENTRIES)
      begin
        eoi_map[i] = (entry_q[i][`VLRS_F_ST_HI:`VLRS_F_ST_LO] ==
                      `VLRS_ST_INVALID) && !entry_q[i][`VLRS_F_LINK] &&
                     entry_q[i][`VLRS_F_EOI];
        empty_map[i] = (entry_q[i][`VLRS_F_ST_HI:`VLRS_F_ST_LO] ==
                        `VLRS_ST_INVALID) && (entry_q[i][`VLRS_F_LINK] ||
                        !entry_q[i][`VLRS_F_EOI]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active priorities next value
  always @*
  begin
    low_bit = apr_q & (~apr_q + 32'h1);
    apr_d   = apr_q;
    if (reg_wr && reg_addr == `VLRS_ADDR_APR)
      apr_d = reg_wdata;
    if (eoi_valid)
      apr_d = apr_d & ~low_bit;
    if (ack_valid && ack_entry < NUM_ENTRIES)
      apr_d = apr_d | (32'h1 << ack_e[`VLRS_F_PRI_HI:`VLRS_F_PRI_LO]);
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      apr_q <= `VLRS_APR_RESET;
    else
      apr_q <= apr_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry storage and life cycle
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (j = 0; j < `VLRS_MAX_ENTRIES; j = j + 1)
        entry_q[j] <= 32'h0;
    end
    else
    begin
      if (wr_entry && wr_idx < NUM_ENTRIES)
        entry_q[wr_idx] <= reg_wdata & `VLRS_ENTRY_MASK;
      if (ack_valid && ack_entry < NUM_ENTRIES &&
          ack_e[`VLRS_F_ST_LO])
        entry_q[ack_entry][`VLRS_F_ST_HI:`VLRS_F_ST_LO] <= `VLRS_ST_ACTIVE;
      if (deact_valid && deact_entry < NUM_ENTRIES)
        entry_q[deact_entry][`VLRS_F_ST_HI] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // physical deactivate request
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phys_deact_q         <= 1'b0;
      linked_physical_id_q <= 10'h000;
    end
    else
    begin
      phys_deact_q <= deact_valid && deact_entry < NUM_ENTRIES &&
                      de_e[`VLRS_F_LINK];
      if (deact_valid)
        linked_physical_id_q <= de_e[`VLRS_F_PID_HI:`VLRS_F_PID_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always @*
  begin
    rd_d = 32'h0;
    case (reg_addr)
      `VLRS_ADDR_TYPE:     rd_d = {26'h0, CNT_M1};
      `VLRS_ADDR_MAINT:    rd_d = {31'h0, |eoi_map};
      `VLRS_ADDR_EOI_LO:   rd_d = eoi_map[31:0];
      `VLRS_ADDR_EOI_HI:   rd_d = eoi_map[63:32];
      `VLRS_ADDR_EMPTY_LO: rd_d = empty_map[31:0];
      `VLRS_ADDR_EMPTY_HI: rd_d = empty_map[63:32];
      `VLRS_ADDR_APR:      rd_d = apr_q;
      default:
      begin
        if (reg_addr[7:6] == 2'h1 && wr_idx < NUM_ENTRIES)
          rd_d = entry_q[wr_idx];
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= 32'h0;
      maint_eoi_q <= 1'b0;
    end
    else
    begin
      reg_rdata_q <= reg_rd ? rd_d : 32'h0;
      maint_eoi_q <= |eoi_map;
    end
  end

endmodule // vlrs_status
`default_nettype wire

// file: verification/vlrs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module vlrs_checker #(parameter NUM_ENTRIES = 64)
(
  // inputs
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic        deact_valid,
  // outputs
  input wire logic [31:0] reg_rdata_q,
  input wire logic        phys_deact_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 0)
    else $error("read data not zero");
  a_type_count: assert property ($past(reg_rd && reg_addr == 8'h00)
    |-> reg_rdata_q[5:0] == NUM_ENTRIES - 1) else $error("bad count");
  a_high_raz: assert property ($past(reg_rd && reg_addr inside {3, 5})
    |-> (reg_rdata_q >> (NUM_ENTRIES - 32)) == 0) else $error("raz");
  a_field_raz: assert property ($past(reg_rd && reg_addr >= 8'h40)
    |-> reg_rdata_q[22:20] == 3'h0) else $error("unused bits");
  a_entry_raz: assert property ($past(reg_rd && reg_addr >= 64 + NUM_ENTRIES)
    |-> reg_rdata_q == 0) else $error("entry not zero");
  a_unmapped_zero: assert property ($past(reg_rd && reg_addr inside {[7:63]})
    |-> reg_rdata_q == 0) else $error("hole not zero");
  a_deact_cause: assert property (phys_deact_q |-> $past(deact_valid))
    else $error("stray request");
  a_deact_pulse: assert property (phys_deact_q && !deact_valid
    |=> !phys_deact_q) else $error("request too long");
endmodule // vlrs_checker
bind vlrs_status vlrs_checker #(.NUM_ENTRIES(NUM_ENTRIES)) chk_inst (.*);
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
  localparam int NE = 40;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic ack_valid = 0, eoi_valid = 0, deact_valid = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [5:0] ack_entry = 6'h00, deact_entry = 6'h00;
  logic [31:0] reg_wdata = 32'h0, rdata, d, apr, ent [64];
  logic [63:0] e;
  logic [4:0] p;
  logic [9:0] id;
  wire logic [31:0] reg_rdata_q;
  wire logic [9:0] linked_physical_id_q;
  wire logic phys_deact_q, maint_eoi_q;
  int n_errors = 0, n_checks = 0;
  vlrs_status #(.NUM_ENTRIES(NE)) vlrs_status_inst (.*);
  always #2 sys_clk = ~sys_clk;
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdata = reg_rdata_q;
  endtask
  // one event pulse: 0 ack, 1 eoi, 2 deactivate
  task automatic pulse(input int k, input logic [5:0] n);
    @(posedge sys_clk);
    ack_valid <= k == 0; eoi_valid <= k == 1; deact_valid <= k == 2;
    ack_entry <= n; deact_entry <= n;
    @(posedge sys_clk);
    {ack_valid, eoi_valid, deact_valid} <= 3'h0;
  endtask
  function automatic logic [63:0] bm(input bit eoi_request_flag);
    logic [63:0] r = 64'h0;
    for (int i = 0; i < NE; i++) if (ent[i][29:28] == 2'h0)
      r[i] = eoi_request_flag ? !ent[i][31] && ent[i][19] : ent[i][31] || !ent[i][19];
    return r;
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    test_done;
  end
  initial
  begin
    void'($urandom(32'hFACE));
    for (int i = 0; i < 64; i++) ent[i] = 32'h0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h00);
    `CHK("count", 6'(NE - 1), rdata[5:0])
    rd(8'h06);
    `CHK("apr", 32'h0, rdata)
    rd(8'h10);
    `CHK("hole", 32'h0, rdata)
    repeat (6)
    begin
      for (int i = 0; i < 48; i++)
      begin
        d = $urandom;
        if (d[0]) d[29:28] = 2'h0;
        wr(8'(64 + i), d);
        if (i < NE) ent[i] = d & 32'hFF8FFFFF;
      end
      for (int w = 0; w < 4; w++)
      begin
        rd(8'(2 + w));
        e = bm(w < 2);
        `CHK("bitmap", w[0] ? e[63:32] : e[31:0], rdata)
      end
      `CHK("maint", |bm(1), maint_eoi_q)
    end
    for (int i = 36; i < 48; i++)
    begin
      rd(8'(64 + i));
      `CHK("entry", ent[i], rdata)
    end
    apr = 32'h0;
    for (int k = 0; k < 5; k++)
    begin
      p = $urandom;
      id = $urandom;
      d = {k[0], 1'b0, 2'h1, p, 3'h0, id, 10'h005};
      // deliver a pending entry into entry 1, overwriting whatever it held
      wr(8'h41, d);
      pulse(0, 6'h01);
      apr[p] = 1'b1;
      pulse(2, 6'h01);
      #1 `CHK("deact", {k[0], id}, {phys_deact_q, linked_physical_id_q})
      ent[1] = {d[31:30], 2'h0, d[27:0]};
      rd(8'h41);
      `CHK("state", ent[1], rdata)
      rd(8'h04);
      e = bm(0);
      `CHK("empty", e[31:0], rdata)
      rd(8'h01);
      `CHK("maint reg", {31'h0, |bm(1)}, rdata)
      rd(8'h06);
      `CHK("apr", apr, rdata)
    end
    repeat (3)
    begin
      pulse(1, 6'h00);
      apr = apr & (apr - 1);
      rd(8'h06);
      `CHK("apr", apr, rdata)
    end
    test_done;
  end
endmodule // tb_top
`default_nettype wire
